/* File: verilog/isp_prog_defs.vh */
// Purpose: constants of the serial programming host
// Assumes: 10 MHz system clock, 100 ns period
// Notes:   times in ns, cycle counts derived from them except SCK_HALF_CYC, which is set directly
// Overview of operation
// - power on, reset low, wait 10 us, assert
// - after reset assert wait start-up time
// - power-down: sck low, wait, release mosi
// - deassert reset, 25 ns, release sck, power off
// - enter from run: reset, delay+100 ns, sck low
// - exit: sck low, mosi free, reset off, sck free
// - programmer is master, device is slave
// - whole bytes, full duplex, eight clocks each
// - most significant bit shifted first
// - mode 0, sample rising, change falling
// - sck period 200, high 75, low 50 ns; SCK_HALF_CYC of 2 gives 200 ns per phase, a 400 ns period
// - wait 2.5, 5 or 7.5 ms after commands
`ifndef ISP_PROG_DEFS_VH
`define ISP_PROG_DEFS_VH

// ********************************
// timing
// ********************************
`define CLK_NS        100
`define PWRUP_NS      10000
`define PWRUP_CYC     ((`PWRUP_NS + `CLK_NS - 1) / `CLK_NS)
`define FLOAT_NS      220
`define FLOAT_CYC     ((`FLOAT_NS + `CLK_NS - 1) / `CLK_NS)
`define LAG_NS        50
`define LAG_CYC       ((`LAG_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_DROP_NS   120
`define RST_DROP_CYC  ((`RST_DROP_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_NS       25
`define HOLD_CYC      ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define PWROFF_NS     1000
`define PWROFF_CYC    (`PWROFF_NS / `CLK_NS)
`define SCK_HIGH_NS   75
`define SCK_LOW_NS    50
`define SCK_PERIOD_NS 200
`define SCK_HALF_CYC  2
`define STARTUP_NS    16000000
`define STARTUP_CYC   ((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)
`define WR_NS         2500000
`define WR_CYC        ((`WR_NS + `CLK_NS - 1) / `CLK_NS)
`define AWR_NS        5000000
`define AWR_CYC       ((`AWR_NS + `CLK_NS - 1) / `CLK_NS)
`define ERS_NS        7500000
`define ERS_CYC       ((`ERS_NS + `CLK_NS - 1) / `CLK_NS)

// ********************************
// commands
// ********************************
`define CMD_POWER_UP   3'h0
`define CMD_ENTER      3'h1
`define CMD_EXIT       3'h2
`define CMD_POWER_DOWN 3'h3
`define CMD_WAIT_WR    3'h4
`define CMD_WAIT_AWR   3'h5
`define CMD_WAIT_ERS   3'h6

`endif

/* File: verilog/rx_skid_buffer.v */
// Purpose: two-entry buffer for received bytes
// Assumes: source and sink on the same clock
// Notes:   outputs and in_ready come from flip-flops
`timescale 1ns/100ps
module rx_skid_buffer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  // drain side
  output reg              out_valid,
  output reg  [WIDTH-1:0] out_data,
  input  wire             out_ready
);

  reg [WIDTH-1:0] skid_data;

  always @(posedge clk) begin
    if (sys_rst) begin
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
      skid_data <= {WIDTH{1'b0}};
    end else if (out_ready || !out_valid) begin
      if (!in_ready) begin
        out_data  <= skid_data;
        out_valid <= 1'b1;
        in_ready  <= 1'b1;
      end else begin
        out_valid <= in_valid;
        if (in_valid) begin
          out_data <= in_data;
        end
      end
    end else if (in_valid && in_ready) begin
      skid_data <= in_data;
      in_ready  <= 1'b0;
    end
  end

endmodule

/* File: verilog/isp_programmer.v */
// Purpose: host that powers, enters, drives and leaves serial programming
// Assumes: bench joins pins to the device; sck made here by a divider
// Notes:   long waits are parameters so a simulation can shorten them
`timescale 1ns/100ps
`include "isp_prog_defs.vh"
module isp_programmer #(
  parameter         RST_ACTIVE_HIGH = 1,
  parameter integer SCK_HALF        = `SCK_HALF_CYC,
  parameter integer STARTUP_CYCLES  = `STARTUP_CYC,
  parameter integer WR_CYCLES       = `WR_CYC,
  parameter integer AWR_CYCLES      = `AWR_CYC,
  parameter integer ERS_CYCLES      = `ERS_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // sequence commands
  input  wire       cmd_valid,
  input  wire [2:0] cmd_code,
  output reg        cmd_ready,
  output reg        in_session,
  output reg        powered,
  // bytes to send
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  output reg        tx_ready,
  // bytes received
  output wire       rx_valid,
  output wire [7:0] rx_data,
  input  wire       rx_ready,
  // device pins
  output reg        vdd_en,
  output reg        rst_pin,
  output reg        sck_out,
  output reg        sck_oe_n,
  output reg        mosi_out,
  output reg        mosi_oe_n,
  input  wire       miso
);

  // ********************************
  // states
  // ********************************
  localparam [12:0] S_OFF     = 13'h0001;
  localparam [12:0] S_PWRUP   = 13'h0002;
  localparam [12:0] S_STARTUP = 13'h0004;
  localparam [12:0] S_RUN     = 13'h0008;
  localparam [12:0] S_START   = 13'h0010;
  localparam [12:0] S_SESSION = 13'h0020;
  localparam [12:0] S_SHIFT   = 13'h0040;
  localparam [12:0] S_TAIL    = 13'h0080;
  localparam [12:0] S_BUSY    = 13'h0100;
  localparam [12:0] S_LAG     = 13'h0200;
  localparam [12:0] S_RSTDROP = 13'h0400;
  localparam [12:0] S_HOLD    = 13'h0800;
  localparam [12:0] S_PWROFF  = 13'h1000;

  localparam integer PWRUP_C = `PWRUP_CYC;
  localparam integer START_C = `FLOAT_CYC;
  localparam integer LAG_C   = `LAG_CYC;
  localparam integer DROP_C  = `RST_DROP_CYC;
  localparam integer HOLD_C  = `HOLD_CYC;
  localparam integer DOWN_C  = `PWROFF_CYC;
  localparam integer HALF_C  = SCK_HALF;
  localparam         RST_ON  = (RST_ACTIVE_HIGH != 0);

  reg  [12:0] state;
  reg  [17:0] cnt;
  reg  [2:0]  bit_idx;
  reg  [7:0]  tx_sh;
  reg  [7:0]  rx_sh;
  reg  [1:0]  rise_d;
  reg         pd_pending;
  reg         miso_m;
  reg         miso_s;
  reg         push;
  wire        buf_ready;
  wire        take;
  wire        cmd_take;

  assign take     = tx_valid && tx_ready && (state == S_SESSION);
  assign cmd_take = cmd_valid && cmd_ready && !take;

  // ********************************
  // miso synchroniser
  // ********************************
  always @(posedge clk) begin
    if (sys_rst) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_m <= miso;
      miso_s <= miso_m;
    end
  end

  // ********************************
  // received-bit capture, two cycles after each rising edge
  // ********************************
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_sh <= 8'h00;
    end else if (rise_d[1]) begin
      rx_sh <= {rx_sh[6:0], miso_s};
    end
  end

  // ********************************
  // sequencer
  // ********************************
  always @(posedge clk) begin
    if (sys_rst) begin
      state      <= S_OFF;
      cnt        <= 18'h00000;
      bit_idx    <= 3'h0;
      tx_sh      <= 8'h00;
      rise_d     <= 2'h0;
      pd_pending <= 1'b0;
      push       <= 1'b0;
      cmd_ready  <= 1'b0;
      tx_ready   <= 1'b0;
      in_session <= 1'b0;
      powered    <= 1'b0;
      vdd_en     <= 1'b0;
      rst_pin    <= 1'b0;
      sck_out    <= 1'b0;
      sck_oe_n   <= 1'b1;
      mosi_out   <= 1'b0;
      mosi_oe_n  <= 1'b1;
    end else begin
      push      <= 1'b0;
      rise_d    <= {rise_d[0], 1'b0};
      cmd_ready <= 1'b0;
      tx_ready  <= 1'b0;
      if (cnt != 18'h00000) begin
        cnt <= cnt - 18'h00001;
      end
      case (state)
        S_OFF: begin
          rst_pin   <= 1'b0;
          cmd_ready <= !cmd_take;
          if (cmd_take && cmd_code == `CMD_POWER_UP) begin
            vdd_en  <= 1'b1;
            powered <= 1'b1;
            cnt     <= PWRUP_C[17:0];
            state   <= S_PWRUP;
          end
        end
        S_PWRUP: begin
          if (cnt == 18'h00000) begin
            rst_pin <= RST_ON;
            cnt     <= STARTUP_CYCLES[17:0];
            state   <= S_STARTUP;
          end
        end
        S_STARTUP: begin
          if (cnt == 18'h00000) begin
            sck_oe_n   <= 1'b0;
            mosi_oe_n  <= 1'b0;
            in_session <= 1'b1;
            state      <= S_SESSION;
          end
        end
        S_RUN: begin
          cmd_ready <= !cmd_take;
          if (cmd_take && cmd_code == `CMD_ENTER) begin
            rst_pin <= RST_ON;
            cnt     <= START_C[17:0];
            state   <= S_START;
          end else if (cmd_take && cmd_code == `CMD_POWER_DOWN) begin
            vdd_en  <= 1'b0;
            powered <= 1'b0;
            rst_pin <= 1'b0;
            state   <= S_OFF;
          end
        end
        S_START: begin
          if (cnt == 18'h00000) begin
            sck_out    <= 1'b0;
            sck_oe_n   <= 1'b0;
            mosi_oe_n  <= 1'b0;
            in_session <= 1'b1;
            state      <= S_SESSION;
          end
        end
        S_SESSION: begin
          tx_ready  <= buf_ready && !push && !cmd_valid && !take;
          cmd_ready <= !cmd_take && !take;
          if (take) begin
            tx_sh    <= tx_data;
            mosi_out <= tx_data[7];
            bit_idx  <= 3'h0;
            cnt      <= HALF_C[17:0] - 18'h00001;
            state    <= S_SHIFT;
          end else if (cmd_take) begin
            case (cmd_code)
              `CMD_EXIT, `CMD_POWER_DOWN: begin
                sck_out    <= 1'b0;
                pd_pending <= (cmd_code == `CMD_POWER_DOWN);
                cnt        <= LAG_C[17:0];
                state      <= S_LAG;
              end
              `CMD_WAIT_WR: begin
                cnt   <= WR_CYCLES[17:0];
                state <= S_BUSY;
              end
              `CMD_WAIT_AWR: begin
                cnt   <= AWR_CYCLES[17:0];
                state <= S_BUSY;
              end
              `CMD_WAIT_ERS: begin
                cnt   <= ERS_CYCLES[17:0];
                state <= S_BUSY;
              end
              default: state <= S_SESSION;
            endcase
          end
        end
        S_SHIFT: begin
          if (cnt == 18'h00000) begin
            cnt     <= HALF_C[17:0] - 18'h00001;
            sck_out <= !sck_out;
            if (!sck_out) begin
              rise_d[0] <= 1'b1;
            end else if (bit_idx == 3'h7) begin
              state <= S_TAIL;
            end else begin
              tx_sh    <= {tx_sh[6:0], 1'b0};
              mosi_out <= tx_sh[6];
              bit_idx  <= bit_idx + 3'h1;
            end
          end
        end
        S_TAIL: begin
          if (rise_d == 2'h0 && !push) begin
            push  <= 1'b1;
            state <= S_SESSION;
          end
        end
        S_BUSY: begin
          if (cnt == 18'h00000) begin
            state <= S_SESSION;
          end
        end
        S_LAG: begin
          if (cnt == 18'h00000) begin
            mosi_oe_n <= 1'b1;
            cnt       <= DROP_C[17:0];
            state     <= S_RSTDROP;
          end
        end
        S_RSTDROP: begin
          if (cnt == 18'h00000) begin
            rst_pin    <= !RST_ON;
            in_session <= 1'b0;
            cnt        <= HOLD_C[17:0];
            state      <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (cnt == 18'h00000) begin
            sck_oe_n <= 1'b1;
            if (pd_pending) begin
              cnt   <= DOWN_C[17:0] - 18'h00001;
              state <= S_PWROFF;
            end else begin
              state <= S_RUN;
            end
          end
        end
        S_PWROFF: begin
          if (cnt == 18'h00000) begin
            vdd_en  <= 1'b0;
            powered <= 1'b0;
            rst_pin <= 1'b0;
            state   <= S_OFF;
          end
        end
        default: state <= S_OFF;
      endcase
    end
  end

  // ********************************
  // received-byte buffer
  // ********************************
  rx_skid_buffer #(
    .WIDTH (8)
  ) u_rx_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_data   (rx_sh),
    .in_ready  (buf_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );
endmodule

/* File: tb/isp_programmer_checker.sv */
// Purpose: pin sequence assertions of the programming host
// Assumes: reset pin active high
// Notes:   bound to the host top module
`timescale 1ns/100ps
module isp_programmer_checker #(
  parameter integer SCK_HALF = 2
) (
  // clock and reset
  input wire       clk,
  input wire       sys_rst,
  // received bytes
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       rx_ready,
  // device pins
  input wire       vdd_en,
  input wire       rst_pin,
  input wire       sck_out,
  input wire       sck_oe_n,
  input wire       mosi_out,
  input wire       mosi_oe_n
);
  reg [7:0] pw;
  reg [3:0] ph;
  reg       sck_q;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // cycles since power on and since the last sck change
  always @(posedge clk) begin
    if (sys_rst) begin
      pw <= 8'h00;
      ph <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      pw <= vdd_en ? pw + {7'h00, pw != 8'hff} : 8'h00;
      ph <= (sck_out != sck_q) ? 4'h1 : ph + {3'h0, ph != 4'hf};
      sck_q <= sck_out;
    end
  end

  a_power_reset_wait: assert property (vdd_en && pw < 8'h64 |-> !rst_pin)
    else $error("reset raised too soon after power on");
  a_sck_start_low: assert property ($fell(sck_oe_n) |-> !sck_out)
    else $error("sck not low when first driven");
  a_mosi_hold_high: assert property (sck_out |-> $stable(mosi_out))
    else $error("mosi changed while sck high");
  a_sck_phase_min: assert property (sck_out != sck_q && !sck_oe_n |-> ph >= SCK_HALF)
    else $error("sck phase too short");
  a_mosi_free_late: assert property ($rose(mosi_oe_n) |->
    !sck_out && !$past(sck_out) && !$past(sck_out, 2)) else $error("mosi released early");
  a_reset_then_sck: assert property ($rose(sck_oe_n) |->
    !rst_pin && !$past(rst_pin) && mosi_oe_n) else $error("sck released early");
  a_power_off_last: assert property ($fell(vdd_en) |-> sck_oe_n && mosi_oe_n && !rst_pin)
    else $error("power removed with pins driven");
  a_settle_before_sck: assert property ($fell(sck_oe_n) |-> rst_pin && $past(rst_pin, 3))
    else $error("sck driven before reset settled");
  a_mosi_needs_reset: assert property (!mosi_oe_n |-> rst_pin && !sck_oe_n)
    else $error("mosi driven outside a session");
  a_rx_word_held: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("received byte lost while stalled");
endmodule

bind isp_programmer isp_programmer_checker #(.SCK_HALF(SCK_HALF)) checker_i (.clk(clk),
  .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
  .vdd_en(vdd_en), .rst_pin(rst_pin), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
  .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n));

/* File: tb/isp_device_model.sv */
// Purpose: serial slave of the programmed device
// Assumes: reset pin active high, mode 0 link
// Notes:   answers each byte with the byte before it
`timescale 1ns/100ps
module isp_device_model (
  // pins
  input  wire       rst_pin,
  input  wire       sck,
  input  wire       mosi,
  output wire       miso,
  // observation
  output reg  [7:0] got,
  output reg  [7:0] got_cnt
);
  reg [7:0] rx;
  reg [7:0] tx;
  reg [2:0] cnt;
  reg       last;

  initial begin
    rx = 8'h00;
    tx = 8'ha5;
    cnt = 3'h0;
    last = 1'b0;
    got = 8'h00;
    got_cnt = 8'h00;
  end
  // entry starts a fresh byte
  always @(posedge rst_pin) begin
    cnt = 3'h0;
    tx = 8'ha5;
  end
  always @(posedge sck) if (rst_pin) begin
    rx = {rx[6:0], mosi};
    cnt = cnt + 3'h1;
    if (cnt == 3'h0) begin
      got = rx;
      got_cnt = got_cnt + 8'h01;
    end
  end
  always @(negedge sck) if (rst_pin) tx = (cnt == 3'h0) ? got : {tx[6:0], 1'b0};
  always @(rst_pin or tx) if (rst_pin) last = tx[7];
  assign miso = rst_pin ? tx[7] : ~last;
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the programming host
// Assumes: device model echoes the previous byte
// Notes:   long waits shortened by parameters
`timescale 1ns/100ps
module testbench;
  reg        clk, sys_rst, cmd_valid, tx_valid, rx_ready, sink_on;
  reg  [2:0] cmd_code;
  reg  [7:0] tx_data, prev;
  reg [31:0] rnd, sink_rnd;
  wire       cmd_ready, in_session, powered, tx_ready, rx_valid, miso;
  wire       vdd_en, rst_pin, sck_out, sck_oe_n, mosi_out, mosi_oe_n;
  wire [7:0] rx_data, dev_byte, dev_cnt;
  integer    failures, cmp_count, cyc, busy, i;
  reg  [7:0] sent[$], expq[$], gotq[$], devq[$];
  // released sck is pulled low, released mosi pulled high
  wire       sck_w  = sck_oe_n ? 1'b0 : sck_out;
  wire       mosi_w = mosi_oe_n ? 1'b1 : mosi_out;

  isp_programmer #(.SCK_HALF(4), .STARTUP_CYCLES(20), .WR_CYCLES(20), .AWR_CYCLES(30),
    .ERS_CYCLES(40)) isp_programmer_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .in_session(in_session), .powered(powered),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .vdd_en(vdd_en), .rst_pin(rst_pin),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso(miso));
  isp_device_model isp_device_model_i (.rst_pin(rst_pin), .sck(sck_w), .mosi(mosi_w),
    .miso(miso), .got(dev_byte), .got_cnt(dev_cnt));

  task chk8(input [8*12:1] what, input [7:0] exp, input [7:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task chk1(input [8*12:1] what, input exp, input got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  // shortest wait the bench configures for each wait command
  function integer min_wait(input [2:0] c);
    begin
      min_wait = (c == 3'h4) ? 20 : ((c == 3'h5) ? 30 : 40);
    end
  endfunction
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task cmd(input [2:0] c);
    begin
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
      cmd_valid <= 1'b0;
      busy = 0;
      @(posedge clk);
      while (cmd_ready !== 1'b1) begin
        @(posedge clk);
        busy = busy + 1;
      end
    end
  endtask
  // the reply to each byte is the byte sent before it
  task send(input [7:0] b);
    begin
      tx_valid <= 1'b1;
      tx_data <= b;
      @(posedge clk);
      while (tx_ready !== 1'b1) @(posedge clk);
      tx_valid <= 1'b0;
      sent.push_back(b);
      expq.push_back(prev);
      prev = b;
      @(posedge clk);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      failures = failures + 1;
      complete_run;
    end
    sink_rnd = $urandom;
    rx_ready <= sink_on & sink_rnd[0];
    if (rx_valid === 1'b1 && rx_ready === 1'b1) gotq.push_back(rx_data);
  end
  always @(dev_cnt) if (dev_cnt > 0) #1 devq.push_back(dev_byte);

  initial begin
    {sys_rst, cmd_valid, tx_valid, rx_ready, sink_on} = 5'h10;
    cmd_code = 3'h0;
    tx_data = 8'h00;
    prev = 8'ha5;
    {failures, cmp_count, cyc} = 0;
    rnd = $urandom(32'ha0d3b192);
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    cmd(3'h0);
    chk1("session", 1'b1, in_session);
    chk1("powered", 1'b1, powered);
    chk1("reset pin", 1'b1, rst_pin);
    send(8'h80);
    send(8'h01);
    repeat (300) @(posedge clk);
    chk1("tx ready", 1'b0, tx_ready);
    chk1("rx valid", 1'b1, rx_valid);
    sink_on <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $urandom;
      send(rnd[7:0]);
    end
    for (i = 4; i < 7; i = i + 1) begin
      cmd(i[2:0]);
      chk1("wait length", 1'b1, busy >= min_wait(i[2:0]));
    end
    cmd(3'h2);
    chk1("run reset", 1'b0, rst_pin);
    chk1("run power", 1'b1, vdd_en);
    chk1("sck free", 1'b1, sck_oe_n);
    cmd(3'h4);
    chk1("refused", 1'b0, in_session);
    cmd(3'h1);
    chk1("entered", 1'b1, in_session);
    prev = 8'ha5;
    send(8'h3c);
    send(8'hc3);
    cmd(3'h3);
    chk1("powered off", 1'b0, vdd_en);
    chk1("mosi free", 1'b1, mosi_oe_n);
    chk1("supply flag", 1'b0, powered);
    cmd(3'h0);
    cmd(3'h2);
    cmd(3'h3);
    chk1("run off", 1'b0, vdd_en);
    chk1("run off rst", 1'b0, rst_pin);
    while (gotq.size() < sent.size()) @(posedge clk);
    chk1("byte count", 1'b1, sent.size() === devq.size());
    for (i = 0; i < sent.size(); i = i + 1) begin
      chk8("mosi byte", sent[i], devq[i]);
      chk8("miso byte", expq[i], gotq[i]);
    end
    complete_run;
  end
endmodule
